// File: tb/ims_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
// ===========================================
// slave: sends a byte msb first, or jams sda
module ims_slave_model (
    // bus
    input  wire logic       scl,
    // control
    input  wire logic       send,
    input  wire logic       jam,
    input  wire logic [7:0] data,
    // line
    output var  logic       sda_oe_n
);
    logic [3:0] n;
    always @(posedge send) n = 4'h0;
    // next bit goes out while scl is low
    always @(negedge scl) if (send) n = n + 4'h1;
    // released line is pulled up, so it never keeps the last bit
    assign sda_oe_n = jam ? 1'b0 :
                      (send && n < 4'h8) ? data[3'(4'h7 - n)] : 1'b1;
endmodule : ims_slave_model
`default_nettype wire

// File: tb/ims_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ims_defs.svh"
module ims_top_tb;
    import ims_pkg::*;
    logic         clk = 1'b0, arst_n = 1'b0, sleep_mode = 1'b0;
    logic         send = 1'b0, jam = 1'b0;
    logic [7:0]   data = 8'h00;
    ims_av_req_t  req = '0;
    ims_av_rsp_t  rsp;
    ims_pin_in_t  pi;
    ims_pin_out_t po;
    logic         irq, wake, s_oe_n, scl, sda;
    logic [31:0]  q;
    int           n_errors = 0, n_checks = 0;
    // wired-and with pull-ups
    assign scl = po.scl_oe_n;
    assign sda = po.sda_oe_n & s_oe_n;
    assign pi  = {scl, sda};
    ims_top ims_top_inst (.clk(clk), .arst_n(arst_n), .av_req(req),
        .av_rsp(rsp), .pin_in(pi), .pin_out(po), .sleep_mode(sleep_mode),
        .irq(irq), .wake(wake));
    ims_slave_model ims_slave_model_inst (.scl(scl), .send(send), .jam(jam),
        .data(data), .sda_oe_n(s_oe_n));
    always #20 clk = ~clk;
    // ===========================================
    // bus access and compares
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        req <= '{~w, w, a, d};
        // no cycle count assumed: only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req <= '0;
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rc(input logic [4:0] a, input logic [31:0] m, e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg_%h", a), q & m, e);
    endtask : rc
    task automatic wt(input logic [31:0] m);
        for (int k = 0; k < 300; k++) begin
            bus(1'b0, `IMS_OFS_CTRL, 32'h0);
            if ((q & m) == 32'h0) break;
        end
        chk("ctrl_req", q & m, 32'h0);
    endtask : wt
    task automatic ws(input logic [31:0] m);
        do bus(1'b0, `IMS_OFS_STAT, 32'h0);
        while ((q & m) != m);
        chk("stat_wait", q & m, m);
    endtask : ws
    task automatic rx(input logic [7:0] b);
        data <= b;
        send <= 1'b1;
        bus(1'b1, `IMS_OFS_CTRL, 32'h1C4);
        bus(1'b1, `IMS_OFS_BUF, 32'h55);
        wt(32'h4);
        send <= 1'b0;
    endtask : rx
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    // ===========================================
    // watchdog, far above the expected run
    initial begin
        #2000000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rc(`IMS_OFS_CTRL, '1, 32'h0);
        rc(`IMS_OFS_STAT, '1, 32'h0);
        rc(`IMS_OFS_RELOAD, '1, 32'h13);
        rc(5'h10, '1, 32'h0);
        bus(1'b1, `IMS_OFS_RELOAD, 32'h3);
        bus(1'b1, `IMS_OFS_CTRL, 32'h1C0);
        bus(1'b1, `IMS_OFS_CTRL, 32'h1C1);
        wt(32'h1);
        rc(`IMS_OFS_STAT, 32'hE, 32'hA);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        chk("wake", {31'h0, wake}, 32'h1);
        sleep_mode <= 1'b0;
        bus(1'b1, `IMS_OFS_STAT, 32'h8);
        // transmit one byte; nobody answers, so the ack bit reads high
        bus(1'b1, `IMS_OFS_BUF, 32'h5A);
        ws(32'h8);
        rc(`IMS_OFS_CTRL, 32'h20, 32'h20);
        rc(`IMS_OFS_STAT, 32'h1, 32'h0);
        bus(1'b1, `IMS_OFS_STAT, 32'h8);
        rx(8'hA5);
        rc(`IMS_OFS_STAT, 32'h29, 32'h29);
        rc(`IMS_OFS_BUF, '1, 32'hA5);
        rc(`IMS_OFS_STAT, 32'h1, 32'h0);
        rx(8'h3C);
        rx(8'h3C);
        rc(`IMS_OFS_STAT, 32'h40, 32'h40);
        bus(1'b1, `IMS_OFS_STAT, 32'h78);
        bus(1'b1, `IMS_OFS_CTRL, 32'h1D8);
        wt(32'h8);
        rc(`IMS_OFS_STAT, 32'h8, 32'h8);
        bus(1'b1, `IMS_OFS_STAT, 32'h8);
        bus(1'b1, `IMS_OFS_CTRL, 32'h1C2);
        wt(32'h2);
        rc(`IMS_OFS_STAT, 32'hC, 32'hC);
        jam <= 1'b1;
        bus(1'b1, `IMS_OFS_CTRL, 32'h1C1);
        wt(32'h1);
        rc(`IMS_OFS_STAT, 32'h10, 32'h10);
        chk("irq", {31'h0, irq}, 32'h1);
        jam <= 1'b0;
        bus(1'b1, `IMS_OFS_CTRL, 32'h0);
        rc(`IMS_OFS_STAT, 32'h6, 32'h0);
        finish_test();
    end
endmodule : ims_top_tb
`default_nettype wire

// File: verilog/ims_defs.svh
// Operation
// - receive request accepted only while the sequencer is idle
// - receive: divider runs, scl toggles each rollover, sda shifted in
// - after 8th falling edge: end receive, copy byte, set flags, hold scl low
// - buffer full set on byte load, cleared by a cpu buffer read
// - byte completes while buffer still full: set receive overflow
// - buffer write while busy sets write collision and is discarded
// - ack start pulls scl low and drives the ack value on sda
// - ack: one period, release scl, once high one period, scl low, idle
// - stop: sda low, then count, release scl, one period later release sda
// - stop seen on bus sets halt; a period later stop done, irq flag
// - in sleep, a pending enabled SPIF interrupt wakes the processor; BCL does not
// - reset disables the module and ends any transfer
// - halt and begin flags cleared on reset or while disabled
// - busy bus with interrupt enabled: stop detected sets irq flag
// - sda arbitration checked in address, data, start and acknowledge
// - released sda read low while scl high: collision, back to idle
// - collision in transmit: halt, clear buffer full, release both lines
// - collision in start, stop or ack: abort, release, clear request
// - new buffer write after collision starts from the first bit
// - start aborted with collision if lines low or scl drops early
// - start: sda low early or at count end, scl low a count later
// - divider reloads from reload register, each rollover one period
`ifndef IMS_DEFS_SVH
`define IMS_DEFS_SVH
// register byte offsets
`define IMS_OFS_CTRL   5'h00
`define IMS_OFS_STAT   5'h04
`define IMS_OFS_BUF    5'h08
`define IMS_OFS_RELOAD 5'h0C
// control register fields
`define IMS_C_START    0
`define IMS_C_STOP     1
`define IMS_C_RECEIVE_ENABLE_BIT     2
`define IMS_C_ACK_SEQUENCE_START    3
`define IMS_C_ACK_VALUE_BIT    4
`define IMS_C_ACKST    5
`define IMS_C_EN       6
`define IMS_C_IE       7
`define IMS_C_BIE      8
`define IMS_CTRL_W     9
`define IMS_REQ_W      4
`define IMS_CTRL_RST   9'h000
// status register fields
`define IMS_S_BF       0
`define IMS_S_BEGIN    1
`define IMS_S_HALT     2
`define IMS_S_SPIF     3
`define IMS_S_BCL      4
`define IMS_S_WRITE_COLLISION_FLAG     5
`define IMS_S_OVF      6
`define IMS_STAT_W     7
`define IMS_STAT_RST   7'h00
// divider
`define IMS_RELOAD_RST 8'h13
`define IMS_LAST_RX    4'h7
`define IMS_ACK_BIT    4'h8
`endif

// File: verilog/ims_pkg.sv
`default_nettype none
package ims_pkg;
    typedef enum logic [3:0] {
        S_IDLE     = 4'h0,
        S_ST_ONE   = 4'h1,
        S_ST_TWO   = 4'h3,
        S_DAT_LOW  = 4'h2,
        S_DAT_HIGH = 4'h6,
        S_ACK_LOW  = 4'h7,
        S_ACK_HIGH = 4'h5,
        S_SP_LOW   = 4'h4,
        S_SP_CNT   = 4'hC,
        S_SP_SCL   = 4'hD,
        S_SP_END   = 4'hF
    } ims_state_t;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } ims_av_req_t;
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } ims_av_rsp_t;
    typedef struct packed {
        logic scl_i;
        logic sda_i;
    } ims_pin_in_t;
    typedef struct packed {
        logic scl_o;
        logic scl_oe_n;
        logic sda_o;
        logic sda_oe_n;
    } ims_pin_out_t;
endpackage : ims_pkg
`default_nettype wire

// File: verilog/ims_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ims_defs.svh"

module ims_top (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // avalon-mm slave
    input  wire ims_pkg::ims_av_req_t  av_req,
    output var  ims_pkg::ims_av_rsp_t  av_rsp,
    // i2c lines
    input  wire ims_pkg::ims_pin_in_t  pin_in,
    output var  ims_pkg::ims_pin_out_t pin_out,
    // system
    input  wire logic                  sleep_mode,
    output var  logic                  irq,
    output var  logic                  wake
);
    import ims_pkg::*;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
        return a == o;
    endfunction : hit

    // ==================================================================
    // reset and line synchronisers
    logic       rst_m_q;
    logic       rst_n_q;
    logic [1:0] pin_m_q;
    logic       scl_s;
    logic       sda_s;
    logic       sda_p_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_m_q <= 2'h3;
            scl_s   <= 1'b1;
            sda_s   <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            pin_m_q <= {pin_in.scl_i, pin_in.sda_i};
            scl_s   <= pin_m_q[1];
            sda_s   <= pin_m_q[0];
            sda_p_q <= sda_s;
        end
    end

    // bus start and stop seen on the wire, whoever made them
    logic start_det;
    logic stop_det;
    assign start_det = scl_s && sda_p_q && !sda_s;
    assign stop_det  = scl_s && !sda_p_q && sda_s;

    // ==================================================================
    // avalon slave: one wait cycle, then the access is taken
    logic [31:0]            wd;
    logic                   acc;
    logic                   wr_ctrl;
    logic                   wr_stat;
    logic                   wr_buf;
    logic                   wr_rel;
    logic                   rd_buf;
    logic [31:0]            rdata;
    logic [`IMS_CTRL_W-1:0] ctrl_q;
    logic [`IMS_STAT_W-1:0] stat_q;
    logic [7:0]             buf_q;
    logic [7:0]             reload_q;

    assign wd      = av_req.writedata;
    assign acc     = (av_req.read || av_req.write) && !av_rsp.waitrequest;
    assign wr_ctrl = acc && av_req.write && hit(av_req.address, `IMS_OFS_CTRL);
    assign wr_stat = acc && av_req.write && hit(av_req.address, `IMS_OFS_STAT);
    assign wr_buf  = acc && av_req.write && hit(av_req.address, `IMS_OFS_BUF);
    assign wr_rel  = acc && av_req.write
                     && hit(av_req.address, `IMS_OFS_RELOAD);
    assign rd_buf  = acc && av_req.read && hit(av_req.address, `IMS_OFS_BUF);

    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(av_req.address, `IMS_OFS_CTRL))
            rdata[`IMS_CTRL_W-1:0] = ctrl_q;
        if (hit(av_req.address, `IMS_OFS_STAT))
            rdata[`IMS_STAT_W-1:0] = stat_q;
        if (hit(av_req.address, `IMS_OFS_BUF))
            rdata[7:0] = buf_q;
        if (hit(av_req.address, `IMS_OFS_RELOAD))
            rdata[7:0] = reload_q;
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            av_rsp.waitrequest <= 1'b1;
            av_rsp.readdata    <= 32'h0000_0000;
        end else begin
            av_rsp.waitrequest <= !((av_req.read || av_req.write)
                                    && av_rsp.waitrequest);
            av_rsp.readdata    <= rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q)
            reload_q <= `IMS_RELOAD_RST;
        else if (wr_rel)
            reload_q <= wd[7:0];
    end

    // ==================================================================
    // baud divider
    ims_state_t           state_q;
    ims_state_t           state_d;
    logic [7:0]           brg_q;
    logic                 stall;
    logic                 brg_load;
    logic                 tick;
    logic                 en;
    logic [`IMS_REQ_W-1:0] req;

    assign en  = ctrl_q[`IMS_C_EN];
    assign req = ctrl_q[`IMS_REQ_W-1:0];
    // a released scl held low by a slave stretches the high phase
    assign stall = (state_q == S_DAT_HIGH || state_q == S_ACK_HIGH
                    || state_q == S_SP_SCL) && !scl_s;
    assign brg_load = state_q == S_IDLE || state_q == S_SP_LOW || stall
                      || (state_q == S_ST_ONE && !sda_s);
    assign tick = brg_q == 8'h00 && !stall && state_q != S_IDLE;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q)
            brg_q <= 8'h00;
        else if (brg_load || brg_q == 8'h00)
            brg_q <= reload_q;
        else
            brg_q <= brg_q - 8'h01;
    end

    // ==================================================================
    // sequencer
    logic [7:0]            sr_q;
    logic [7:0]            sr_d;
    logic [3:0]            bit_q;
    logic [3:0]            bit_d;
    logic                  rx_q;
    logic                  rx_d;
    logic                  scl_d;
    logic                  sda_d;
    logic                  coll;
    logic                  tx_go;
    logic                  buf_ld;
    logic [`IMS_REQ_W-1:0] clr_req;
    logic                  ev_spif;
    logic                  ev_bf_set;
    logic                  ev_bf_clr;
    logic                  ev_ack;

    always_comb begin
        state_d   = state_q;
        scl_d     = pin_out.scl_oe_n;
        sda_d     = pin_out.sda_oe_n;
        sr_d      = sr_q;
        bit_d     = bit_q;
        rx_d      = rx_q;
        coll      = 1'b0;
        tx_go     = 1'b0;
        buf_ld    = 1'b0;
        clr_req   = 4'h0;
        ev_spif   = 1'b0;
        ev_bf_set = 1'b0;
        ev_bf_clr = 1'b0;
        ev_ack    = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (req[`IMS_C_START]) begin
                    if (!sda_s || !scl_s)
                        coll = 1'b1;
                    else
                        state_d = S_ST_ONE;
                end else if (req[`IMS_C_STOP]) begin
                    sda_d   = 1'b0;
                    state_d = S_SP_LOW;
                end else if (req[`IMS_C_RECEIVE_ENABLE_BIT]) begin
                    rx_d    = 1'b1;
                    bit_d   = 4'h0;
                    sda_d   = 1'b1;
                    state_d = S_DAT_LOW;
                end else if (req[`IMS_C_ACK_SEQUENCE_START]) begin
                    scl_d   = 1'b0;
                    sda_d   = ctrl_q[`IMS_C_ACK_VALUE_BIT];
                    state_d = S_ACK_LOW;
                end else if (wr_buf && en) begin
                    // always from the first bit, even after a collision
                    tx_go     = 1'b1;
                    rx_d      = 1'b0;
                    bit_d     = 4'h0;
                    sr_d      = wd[7:0];
                    sda_d     = wd[7];
                    scl_d     = 1'b0;
                    ev_bf_set = 1'b1;
                    state_d   = S_DAT_LOW;
                end
            end
            S_ST_ONE: begin
                if (!scl_s && sda_s) begin
                    coll = 1'b1;
                end else if (!sda_s || tick) begin
                    sda_d   = 1'b0;
                    state_d = S_ST_TWO;
                end
            end
            S_ST_TWO: begin
                if (tick) begin
                    scl_d   = 1'b0;
                    clr_req = 4'h1;
                    ev_spif = 1'b1;
                    state_d = S_IDLE;
                end
            end
            S_DAT_LOW: begin
                if (tick) begin
                    scl_d   = 1'b1;
                    state_d = S_DAT_HIGH;
                end
            end
            S_DAT_HIGH: begin
                if (tick) begin
                    scl_d = 1'b0;
                    bit_d = bit_q + 4'h1;
                    if (rx_q) begin
                        sr_d = {sr_q[6:0], sda_s};
                        if (bit_q == `IMS_LAST_RX) begin
                            buf_ld    = 1'b1;
                            ev_bf_set = 1'b1;
                            ev_spif   = 1'b1;
                            clr_req   = 4'h4;
                            state_d   = S_IDLE;
                        end else begin
                            state_d = S_DAT_LOW;
                        end
                    end else if (bit_q == `IMS_ACK_BIT) begin
                        ev_ack  = 1'b1;
                        ev_spif = 1'b1;
                        state_d = S_IDLE;
                    end else if (sr_q[7] && !sda_s) begin
                        coll = 1'b1;
                    end else begin
                        sr_d      = {sr_q[6:0], 1'b0};
                        // after the 8th bit the slave owns sda
                        sda_d     = bit_q == `IMS_LAST_RX || sr_q[6];
                        ev_bf_clr = bit_q == `IMS_LAST_RX;
                        state_d   = S_DAT_LOW;
                    end
                end
            end
            S_ACK_LOW: begin
                if (tick) begin
                    scl_d   = 1'b1;
                    state_d = S_ACK_HIGH;
                end
            end
            S_ACK_HIGH: begin
                if (tick) begin
                    if (ctrl_q[`IMS_C_ACK_VALUE_BIT] && !sda_s) begin
                        coll = 1'b1;
                    end else begin
                        scl_d   = 1'b0;
                        clr_req = 4'h8;
                        ev_spif = 1'b1;
                        state_d = S_IDLE;
                    end
                end
            end
            S_SP_LOW: begin
                if (!sda_s)
                    state_d = S_SP_CNT;
            end
            S_SP_CNT: begin
                if (tick) begin
                    scl_d   = 1'b1;
                    state_d = S_SP_SCL;
                end
            end
            S_SP_SCL: begin
                if (tick) begin
                    sda_d   = 1'b1;
                    state_d = S_SP_END;
                end
            end
            S_SP_END: begin
                if (tick) begin
                    if (!sda_s || !scl_s) begin
                        coll = 1'b1;
                    end else begin
                        clr_req = 4'h2;
                        ev_spif = 1'b1;
                        state_d = S_IDLE;
                    end
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (coll) begin
            scl_d     = 1'b1;
            sda_d     = 1'b1;
            clr_req   = 4'hF;
            ev_bf_clr = state_q == S_DAT_HIGH;
            state_d   = S_IDLE;
        end
        if (!en) begin
            scl_d   = 1'b1;
            sda_d   = 1'b1;
            clr_req = 4'hF;
            tx_go   = 1'b0;
            state_d = S_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= S_IDLE;
            sr_q    <= 8'h00;
            bit_q   <= 4'h0;
            rx_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            sr_q    <= sr_d;
            bit_q   <= bit_d;
            rx_q    <= rx_d;
        end
    end

    // open drain: data level fixed low, only the enables move
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_out <= 4'b0101;
        end else begin
            pin_out.scl_o    <= 1'b0;
            pin_out.sda_o    <= 1'b0;
            pin_out.scl_oe_n <= scl_d;
            pin_out.sda_oe_n <= sda_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q)
            buf_q <= 8'h00;
        else if (buf_ld)
            buf_q <= {sr_q[6:0], sda_s};
        else if (tx_go)
            buf_q <= wd[7:0];
    end

    // ==================================================================
    // control register: a request is taken only when nothing is pending
    logic req_ok;
    assign req_ok = state_q == S_IDLE && req == 4'h0 && en;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= `IMS_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q[`IMS_C_ACK_VALUE_BIT] <= wd[`IMS_C_ACK_VALUE_BIT];
                ctrl_q[`IMS_C_EN]    <= wd[`IMS_C_EN];
                ctrl_q[`IMS_C_IE]    <= wd[`IMS_C_IE];
                ctrl_q[`IMS_C_BIE]   <= wd[`IMS_C_BIE];
            end
            if (wr_ctrl && req_ok)
                ctrl_q[`IMS_REQ_W-1:0] <= wd[`IMS_REQ_W-1:0];
            else
                ctrl_q[`IMS_REQ_W-1:0] <= req & ~clr_req;
            if (ev_ack)
                ctrl_q[`IMS_C_ACKST] <= sda_s;
        end
    end

    // ==================================================================
    // status flags: a hardware set always beats a software clear
    logic [`IMS_STAT_W-1:0] w1c;
    logic                   write_collision_flag_ev;
    logic                   busy_stop;
    assign w1c       = wr_stat ? wd[`IMS_STAT_W-1:0] : `IMS_STAT_RST;
    assign write_collision_flag_ev   = wr_buf && state_q != S_IDLE;
    assign busy_stop = ctrl_q[`IMS_C_IE] && stat_q[`IMS_S_BEGIN] && stop_det;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stat_q <= `IMS_STAT_RST;
        end else begin
            stat_q[`IMS_S_BF]    <= ev_bf_set || (stat_q[`IMS_S_BF]
                                    && !rd_buf && !ev_bf_clr);
            stat_q[`IMS_S_BEGIN] <= en && (start_det
                                    || (stat_q[`IMS_S_BEGIN] && !stop_det));
            stat_q[`IMS_S_HALT]  <= en && (stop_det
                                    || (stat_q[`IMS_S_HALT] && !start_det));
            stat_q[`IMS_S_SPIF]  <= ev_spif || busy_stop
                                    || (stat_q[`IMS_S_SPIF]
                                    && !w1c[`IMS_S_SPIF]);
            stat_q[`IMS_S_BCL]   <= coll || (stat_q[`IMS_S_BCL]
                                    && !w1c[`IMS_S_BCL]);
            stat_q[`IMS_S_WRITE_COLLISION_FLAG]  <= write_collision_flag_ev || (stat_q[`IMS_S_WRITE_COLLISION_FLAG]
                                    && !w1c[`IMS_S_WRITE_COLLISION_FLAG]);
            stat_q[`IMS_S_OVF]   <= (buf_ld && stat_q[`IMS_S_BF])
                                    || (stat_q[`IMS_S_OVF]
                                    && !w1c[`IMS_S_OVF]);
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= (stat_q[`IMS_S_SPIF] && ctrl_q[`IMS_C_IE])
                    || (stat_q[`IMS_S_BCL] && ctrl_q[`IMS_C_BIE]);
            // bus monitor keeps running in sleep and can wake the core
            wake <= sleep_mode && stat_q[`IMS_S_SPIF]
                    && ctrl_q[`IMS_C_IE];
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    sequence s_rx_last;
        state_q == S_DAT_HIGH && rx_q && tick && en
        && bit_q == `IMS_LAST_RX;
    endsequence
    sequence s_ack_end;
        state_q == S_ACK_HIGH && tick && en
        && !(ctrl_q[`IMS_C_ACK_VALUE_BIT] && !sda_s);
    endsequence

    a_receive_enable_bit_ignored: assert property (
        wr_ctrl && wd[`IMS_C_RECEIVE_ENABLE_BIT] && !req_ok && !req[`IMS_C_RECEIVE_ENABLE_BIT]
        |=> !req[`IMS_C_RECEIVE_ENABLE_BIT]) else $error("receive request not ignored");
    a_rx_byte_end: assert property (
        s_rx_last |=> stat_q[`IMS_S_BF] && stat_q[`IMS_S_SPIF]
        && !req[`IMS_C_RECEIVE_ENABLE_BIT] && !pin_out.scl_oe_n && state_q == S_IDLE)
        else $error("receive byte end wrong");
    a_rx_overflow: assert property (
        s_rx_last and stat_q[`IMS_S_BF] |=> stat_q[`IMS_S_OVF])
        else $error("overflow not flagged");
    a_bf_read_clr: assert property (
        rd_buf && !ev_bf_set |=> !stat_q[`IMS_S_BF])
        else $error("buffer full not cleared by read");
    a_write_collision_flag_discard: assert property (
        write_collision_flag_ev && !buf_ld |=> stat_q[`IMS_S_WRITE_COLLISION_FLAG] && $stable(buf_q))
        else $error("write collision mishandled");
    a_ack_drive: assert property (
        state_q == S_IDLE && en && req == 4'h8
        |=> state_q == S_ACK_LOW && !pin_out.scl_oe_n
        && pin_out.sda_oe_n == $past(ctrl_q[`IMS_C_ACK_VALUE_BIT]))
        else $error("ack not driven");
    a_ack_finish: assert property (
        s_ack_end |=> !req[`IMS_C_ACK_SEQUENCE_START] && !pin_out.scl_oe_n
        && state_q == S_IDLE) else $error("ack end wrong");
    a_stop_sda_low: assert property (
        state_q == S_IDLE && en && req == 4'h2
        |=> !pin_out.sda_oe_n && state_q == S_SP_LOW)
        else $error("stop did not pull sda");
    a_coll_release: assert property (
        coll && en |=> stat_q[`IMS_S_BCL] && pin_out.scl_oe_n
        && pin_out.sda_oe_n && req == 4'h0 && state_q == S_IDLE)
        else $error("collision did not release");
    a_start_abort: assert property (
        state_q == S_IDLE && en && req[`IMS_C_START] && (!sda_s || !scl_s)
        |=> stat_q[`IMS_S_BCL] && !req[`IMS_C_START])
        else $error("bad start not aborted");
    a_disable_clr: assert property (
        !en |=> !stat_q[`IMS_S_BEGIN] && !stat_q[`IMS_S_HALT])
        else $error("bus flags not cleared when disabled");
endmodule : ims_top
`default_nettype wire
